/* File: hw/cam_cmd_pkg.sv */
package cam_cmd_pkg;

  // ----------------------------------------
  // Frame bytes
  // ----------------------------------------
  localparam logic [7:0] OP_WRITE = 8'h57;
  localparam logic [7:0] OP_READ = 8'h52;
  localparam logic [7:0] ACK_BYTE = 8'h06;
  localparam logic [7:0] ERR_BYTE = 8'h15;
  localparam int WRITE_LEN = 7;
  localparam int READ_LEN = 3;

  // ----------------------------------------
  // Spaces and storage
  // ----------------------------------------
  localparam logic [2:0] SPACE_FACTORY = 3'h0;
  localparam logic [2:0] SPACE_USER_MAX = 3'h4;
  localparam logic [2:0] BOOT_SEL_RESET = 3'h0;
  localparam int REG_DEPTH = 16;
  localparam int MAP_DEPTH = 16;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Link rates
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam logic [2:0] BAUD_DEFAULT = 3'h4;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_RX = 7'b000_0010,
    ST_EXEC = 7'b000_0100,
    ST_TX = 7'b000_1000,
    ST_COPY = 7'b001_0000,
    ST_BOOT = 7'b010_0000,
    ST_WAIT = 7'b100_0000
  } state_t;

  typedef struct packed {
    logic [2:0] space;
    logic load;
    logic save;
  } space_cmd_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
  } pixel_t;

endpackage

/* File: hw/cam_cmd_parser.sv */
// Functional notes
// - Address two bytes, data four bytes, most significant byte first.
// - Factory load overwrites working registers with factory values.
// - User space load overwrites working registers with that space.
// - Save to any user space; factory save only in technician mode.
// - At power-up registers load from boot_reg, which reset returns to factory space.
// - Pixel maps kept stored; correction applied only when enabled.
// - Separate user and live map areas; host updates go to user.
// - New pixel maps take effect only after camera restart.
// - Map entries hold separate horizontal and vertical coordinates.
// - Serial commands that cannot execute answer with an error byte; failed space commands only set cmd_error.
// - Link rates 9600 to 115200, default 115200.
module cam_cmd_parser
  import cam_cmd_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Serial link
  input wire logic rx_pin,
  output logic tx_pin,
  // Space control and link rate
  input wire space_cmd_t space_cmd,
  input wire logic tech_mode,
  input wire logic [2:0] boot_sel_in,
  input wire logic boot_sel_we,
  input wire logic [2:0] baud_sel,
  // Pixel map download and correction
  input wire logic map_we,
  input wire logic map_hot,
  input wire logic [3:0] map_idx,
  input wire pixel_t map_pix,
  input wire logic bpc_en,
  input wire pixel_t pix_pos,
  output logic pix_fix,
  // Status
  output logic cmd_error,
  output logic busy
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [31:0] work_mem [DEPTH];
  logic [31:0] space_mem [5][DEPTH];
  pixel_t map_user [2][MAP_DEPTH];
  pixel_t map_live [2][MAP_DEPTH];
  logic [2:0] boot_reg;

  // ----------------------------------------
  // Input sync and baud
  // ----------------------------------------
  logic rx_s1_reg, rx_s2_reg;
  logic [15:0] bit_div;
  always_comb begin
    unique case (baud_sel)
      3'h0: bit_div = 16'(CLK_HZ / 9600);
      3'h1: bit_div = 16'(CLK_HZ / 19200);
      3'h2: bit_div = 16'(CLK_HZ / 28400);
      3'h3: bit_div = 16'(CLK_HZ / 57600);
      default: bit_div = 16'(CLK_HZ / 115200);
    endcase
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  logic [15:0] rcnt_reg, rcnt_next;
  logic [3:0] rbit_reg, rbit_next;
  logic [8:0] rsh_reg, rsh_next;
  logic rbusy_reg, rbusy_next, rdone_reg, rdone_next;
  always_comb begin
    rcnt_next = rcnt_reg;
    rbit_next = rbit_reg;
    rsh_next = rsh_reg;
    rbusy_next = rbusy_reg;
    rdone_next = 1'b0;
    if (!rbusy_reg) begin
      if (!rx_s2_reg) begin
        rbusy_next = 1'b1;
        rcnt_next = bit_div >> 1;
        rbit_next = 4'h0;
      end
    end else if (rcnt_reg != 16'h0000) begin
      rcnt_next = rcnt_reg - 16'h0001;
    end else begin
      rcnt_next = bit_div - 16'h0001;
      rsh_next = {rx_s2_reg, rsh_reg[8:1]};
      rbit_next = rbit_reg + 4'h1;
      if (rbit_reg == 4'h9) begin
        rbusy_next = 1'b0;
        rdone_next = rx_s2_reg;
      end
    end
  end
  wire [7:0] rx_byte = rsh_reg[7:0];

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [15:0] tcnt_reg, tcnt_next;
  logic [3:0] tbit_reg, tbit_next;
  logic [9:0] tsh_reg, tsh_next;
  logic tbusy_reg, tbusy_next, tx_reg, tx_next;
  logic tx_go;
  logic [7:0] tx_byte;
  always_comb begin
    tcnt_next = tcnt_reg;
    tbit_next = tbit_reg;
    tsh_next = tsh_reg;
    tbusy_next = tbusy_reg;
    tx_next = tx_reg;
    if (!tbusy_reg) begin
      tx_next = 1'b1;
      if (tx_go) begin
        tbusy_next = 1'b1;
        tsh_next = {1'b1, tx_byte, 1'b0};
        tbit_next = 4'h0;
        tcnt_next = 16'h0000;
      end
    end else if (tcnt_reg != 16'h0000) begin
      tcnt_next = tcnt_reg - 16'h0001;
    end else if (tbit_reg == 4'ha) begin
      tbusy_next = 1'b0;
    end else begin
      tx_next = tsh_reg[0];
      tsh_next = {1'b1, tsh_reg[9:1]};
      tbit_next = tbit_reg + 4'h1;
      tcnt_next = bit_div - 16'h0001;
    end
  end

  // ----------------------------------------
  // Command sequencer
  // ----------------------------------------
  state_t st_reg, st_next;
  logic [7:0] op_reg, op_next;
  logic [2:0] n_reg, n_next;
  logic [47:0] fr_reg, fr_next;
  logic [39:0] out_reg, out_next;
  logic [2:0] left_reg, left_next;
  logic [2:0] src_reg, src_next;
  logic [4:0] idx_reg, idx_next;
  logic to_space_reg, to_space_next;
  logic err_reg, err_next;
  wire [15:0] addr = fr_reg[47:32];
  wire addr_ok = addr < 16'(DEPTH);
  wire [$clog2(DEPTH)-1:0] aidx = addr[$clog2(DEPTH)-1:0];
  wire [$clog2(DEPTH)-1:0] cidx = idx_reg[$clog2(DEPTH)-1:0];
  logic wr_work, wr_space;

  always_comb begin
    st_next = st_reg;
    op_next = op_reg;
    n_next = n_reg;
    fr_next = fr_reg;
    out_next = out_reg;
    left_next = left_reg;
    src_next = src_reg;
    idx_next = idx_reg;
    to_space_next = to_space_reg;
    err_next = err_reg;
    wr_work = 1'b0;
    wr_space = 1'b0;
    tx_go = 1'b0;
    tx_byte = out_reg[39:32];
    unique case (st_reg)
      ST_BOOT: begin
        src_next = boot_reg;
        to_space_next = 1'b0;
        idx_next = 5'h00;
        st_next = ST_COPY;
      end
      ST_IDLE: begin
        if (rdone_reg) begin
          if (rx_byte == OP_WRITE || rx_byte == OP_READ) begin
            op_next = rx_byte;
            n_next = 3'h0;
            st_next = ST_RX;
          end else begin
            out_next = {ERR_BYTE, 32'h0000_0000};
            left_next = 3'h1;
            err_next = 1'b1;
            st_next = ST_TX;
          end
        end else if (space_cmd.load || space_cmd.save) begin
          idx_next = 5'h00;
          src_next = space_cmd.space;
          to_space_next = space_cmd.save;
          if (space_cmd.space > SPACE_USER_MAX) begin
            err_next = 1'b1;
          end else if (space_cmd.save && space_cmd.space == SPACE_FACTORY
                       && !tech_mode) begin
            err_next = 1'b1;
          end else begin
            err_next = 1'b0;
            st_next = ST_COPY;
          end
        end
      end
      ST_RX: begin
        if (rdone_reg) begin
          fr_next = {fr_reg[39:0], rx_byte};
          n_next = n_reg + 3'h1;
          if (op_reg == OP_WRITE && n_reg == 3'(WRITE_LEN - 2)) begin
            st_next = ST_EXEC;
          end else if (op_reg == OP_READ && n_reg == 3'(READ_LEN - 2)) begin
            fr_next = {fr_reg[7:0], rx_byte, 32'h0000_0000};
            st_next = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        st_next = ST_TX;
        if (!addr_ok) begin
          out_next = {ERR_BYTE, 32'h0000_0000};
          left_next = 3'h1;
          err_next = 1'b1;
        end else if (op_reg == OP_WRITE) begin
          wr_work = 1'b1;
          out_next = {ACK_BYTE, 32'h0000_0000};
          left_next = 3'h1;
          err_next = 1'b0;
        end else begin
          out_next = {ACK_BYTE, work_mem[aidx]};
          left_next = 3'h5;
          err_next = 1'b0;
        end
      end
      ST_TX: begin
        tx_go = 1'b1;
        out_next = {out_reg[31:0], 8'h00};
        left_next = left_reg - 3'h1;
        st_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (!tbusy_reg && !tx_go) begin
          st_next = (left_reg == 3'h0) ? ST_IDLE : ST_TX;
        end
      end
      ST_COPY: begin
        wr_work = !to_space_reg;
        wr_space = to_space_reg;
        idx_next = idx_reg + 5'h01;
        if (idx_reg == 5'(DEPTH - 1)) begin
          st_next = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Pixel correction lookup
  // ----------------------------------------
  logic fix_next;
  always_comb begin
    fix_next = 1'b0;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < MAP_DEPTH; k++) begin
        if (map_live[m][k] == pix_pos) begin
          fix_next = bpc_en;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic boot_pend_reg;
  logic busy_reg;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rcnt_reg <= 16'h0000;
      rbit_reg <= 4'h0;
      rsh_reg <= 9'h1ff;
      rbusy_reg <= 1'b0;
      rdone_reg <= 1'b0;
      tcnt_reg <= 16'h0000;
      tbit_reg <= 4'h0;
      tsh_reg <= 10'h3ff;
      tbusy_reg <= 1'b0;
      tx_reg <= 1'b1;
      st_reg <= ST_BOOT;
      op_reg <= 8'h00;
      n_reg <= 3'h0;
      fr_reg <= 48'h0000_0000_0000;
      out_reg <= 40'h00_0000_0000;
      left_reg <= 3'h0;
      src_reg <= 3'h0;
      idx_reg <= 5'h00;
      to_space_reg <= 1'b0;
      err_reg <= 1'b0;
      boot_reg <= BOOT_SEL_RESET;
      pix_fix <= 1'b0;
      boot_pend_reg <= 1'b1;
      busy_reg <= 1'b1;
    end else if (clk_en) begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rcnt_reg <= rcnt_next;
      rbit_reg <= rbit_next;
      rsh_reg <= rsh_next;
      rbusy_reg <= rbusy_next;
      rdone_reg <= rdone_next;
      tcnt_reg <= tcnt_next;
      tbit_reg <= tbit_next;
      tsh_reg <= tsh_next;
      tbusy_reg <= tbusy_next;
      tx_reg <= tx_next;
      st_reg <= st_next;
      op_reg <= op_next;
      n_reg <= n_next;
      fr_reg <= fr_next;
      out_reg <= out_next;
      left_reg <= left_next;
      src_reg <= src_next;
      idx_reg <= idx_next;
      to_space_reg <= to_space_next;
      err_reg <= err_next;
      pix_fix <= fix_next;
      boot_pend_reg <= 1'b0;
      busy_reg <= (st_next != ST_IDLE);
      if (boot_sel_we && boot_sel_in <= SPACE_USER_MAX) begin
        boot_reg <= boot_sel_in;
      end
    end
  end

  // Memories without reset
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (wr_work && st_reg == ST_EXEC) begin
        work_mem[aidx] <= fr_reg[31:0];
      end else if (wr_work) begin
        work_mem[cidx] <= space_mem[src_reg][cidx];
      end
      if (wr_space) begin
        space_mem[src_reg][cidx] <= work_mem[cidx];
      end
      if (map_we) begin
        map_user[map_hot][map_idx] <= map_pix;
      end
      if (boot_pend_reg) begin
        map_live <= map_user;
      end
    end
  end

  assign tx_pin = tx_reg;
  assign cmd_error = err_reg;
  assign busy = busy_reg;

endmodule

/* File: testbench/cam_cmd_parser_asserts.sv */
module cam_cmd_parser_asserts
  import cam_cmd_pkg::*;
#(
  parameter int DEPTH = REG_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Serial link
  input wire logic rx_pin,
  input wire logic tx_pin,
  // Space control and link rate
  input wire space_cmd_t space_cmd,
  input wire logic tech_mode,
  input wire logic [2:0] boot_sel_in,
  input wire logic boot_sel_we,
  input wire logic [2:0] baud_sel,
  // Pixel maps
  input wire logic map_we,
  input wire logic map_hot,
  input wire logic [3:0] map_idx,
  input wire pixel_t map_pix,
  input wire logic bpc_en,
  input wire pixel_t pix_pos,
  input wire logic pix_fix,
  // Status
  input wire logic cmd_error,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BOOT_MAX = DEPTH + 40;
  logic take, fs, big, ok;
  assign take = !busy && clk_en && (space_cmd.load || space_cmd.save);
  assign fs = take && space_cmd.save && !tech_mode
    && space_cmd.space == SPACE_FACTORY;
  assign big = take && space_cmd.space > SPACE_USER_MAX;
  assign ok = take && !fs && !big;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_idle; !busy |-> tx_pin; endproperty
  a_idle: assert property (p_idle) else $error("tx low idle");
  property p_fix; pix_fix |-> $past(bpc_en); endproperty
  a_fix: assert property (p_fix) else $error("fix w/o enable");
  property p_rst; $rose(rstn) |-> !cmd_error && !pix_fix; endproperty
  a_rst: assert property (p_rst) else $error("reset values");
  property p_boot; $rose(rstn) |-> busy[*8]; endproperty
  a_boot: assert property (p_boot) else $error("boot short");
  property p_bend; $rose(rstn) |-> ##[8:BOOT_MAX] !busy; endproperty
  a_bend: assert property (p_bend) else $error("boot long");
  property p_fs; fs |-> ##[1:4] cmd_error; endproperty
  a_fs: assert property (p_fs) else $error("factory save");
  property p_big; big |-> ##[1:4] cmd_error; endproperty
  a_big: assert property (p_big) else $error("bad space");
  property p_ok; ok |-> ##[1:3] busy; endproperty
  a_ok: assert property (p_ok) else $error("no copy");
  property p_okerr; ok |-> ##[1:BOOT_MAX] !cmd_error; endproperty
  a_okerr: assert property (p_okerr) else $error("copy error");
endmodule

bind cam_cmd_parser cam_cmd_parser_asserts #(.DEPTH(DEPTH)) u_chk (.*);

/* File: testbench/host_link.sv */
module host_link
  import cam_cmd_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Serial lines
  input wire logic tx_pin,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = CLK_HZ / 115200;
  logic [7:0] got[$];

  initial rx_pin = 1'b1;

  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin = f[i];
      repeat (BIT) @(posedge sys_clk);
      #1;
    end
  endtask

  initial begin
    logic [7:0] b;
    forever begin
      @(negedge tx_pin);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge sys_clk);
        b[i] = tx_pin;
      end
      repeat (BIT) @(posedge sys_clk);
      got.push_back(b);
    end
  end
endmodule

/* File: testbench/camera_serial_register_command_parser_bench.sv */
module camera_serial_register_command_parser_bench
  import cam_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
  logic sys_clk, rstn, clk_en, rx_pin, tx_pin, tech_mode;
  logic boot_sel_we, map_we, map_hot, bpc_en, pix_fix, cmd_error, busy;
  logic [2:0] boot_sel_in, baud_sel, us;
  logic [3:0] map_idx;
  logic [31:0] dat;
  logic [7:0] adr, op;
  space_cmd_t space_cmd;
  pixel_t map_pix, pix_pos, np;
  pixel_t tab[32];
  int fails, n_compared, j;

  cam_cmd_parser u_dut (.*);
  host_link u_host (.sys_clk(sys_clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_idle();
    for (int t = 0; t < 300 && busy !== 1'b0; t++) tick(1);
    if (busy !== 1'b0) fails++;
  endtask

  task automatic exp_rx(input logic [7:0] b);
    logic [7:0] g;
    for (int t = 0; t < 6000 && u_host.got.size() == 0; t++) tick(1);
    g = 8'hxx;
    if (u_host.got.size() > 0) g = u_host.got.pop_front();
    `CHK(g, b)
  endtask

  function automatic logic exp_err(input logic [2:0] s, input logic sv, tm);
    return (s > SPACE_USER_MAX) || (sv && s == SPACE_FACTORY && !tm);
  endfunction

  task automatic scmd(input logic [2:0] s, input logic ld, sv);
    space_cmd = '{s, ld, sv};
    tick(1);
    space_cmd = '0;
    tick(3);
    wait_idle();
    `CHK(cmd_error, exp_err(s, sv, tech_mode))
  endtask

  task automatic mapw(input logic [4:0] k, input pixel_t p);
    {map_hot, map_idx} = k;
    map_pix = p;
    map_we = 1'b1;
    tick(1);
    map_we = 1'b0;
    tick(1);
  endtask

  task automatic fix(input pixel_t p, input logic en, e);
    pix_pos = p;
    bpc_en = en;
    tick(2);
    `CHK(pix_fix, e)
  endtask

  task automatic restart();
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(1);
    `CHK(busy, 1'b1)
    `CHK(cmd_error, 1'b0)
    wait_idle();
  endtask

  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge sys_clk);
    fails++;
    test_done();
  end

  initial begin
    void'($urandom(79));
    {rstn, tech_mode, boot_sel_we, map_we, map_hot, bpc_en} = '0;
    {boot_sel_in, map_idx, space_cmd, map_pix, pix_pos} = '0;
    clk_en = 1'b1;
    baud_sel = BAUD_DEFAULT;
    tick(16);
    rstn = 1'b1;
    wait_idle();
    op = OP_WRITE;
    while (op == OP_WRITE || op == OP_READ) op = 8'($urandom_range(255));
    u_host.send(op);
    exp_rx(ERR_BYTE);
    `CHK(cmd_error, 1'b1)
    adr = 8'($urandom_range(REG_DEPTH - 1));
    dat = $urandom;
    tick(500);
    u_host.send(OP_WRITE);
    u_host.send(8'h00);
    u_host.send(adr);
    for (int i = 3; i >= 0; i--) u_host.send(dat[i*8+:8]);
    exp_rx(ACK_BYTE);
    `CHK(cmd_error, 1'b0)
    tick(500);
    baud_sel = 3'($urandom_range(7, 4));
    u_host.send(OP_READ);
    u_host.send(8'h00);
    u_host.send(adr);
    exp_rx(ACK_BYTE);
    for (int i = 3; i >= 0; i--) exp_rx(dat[i*8+:8]);
    tick(500);
    wait_idle();
    us = 3'($urandom_range(4, 1));
    scmd(SPACE_FACTORY, 1'b0, 1'b1);
    scmd(us, 1'b0, 1'b1);
    scmd(3'h5 + 3'($urandom_range(2)), 1'b1, 1'b0);
    scmd(SPACE_FACTORY, 1'b1, 1'b0);
    tech_mode = 1'b1;
    scmd(SPACE_FACTORY, 1'b0, 1'b1);
    tech_mode = 1'b0;
    scmd(us, 1'b1, 1'b0);
    boot_sel_in = 3'h7;
    boot_sel_we = 1'b1;
    tick(1);
    boot_sel_in = us;
    tick(1);
    boot_sel_we = 1'b0;
    for (j = 0; j < 32; j++) begin
      tab[j] = '{16'h1000 + 16'(j), 16'($urandom)};
      mapw(5'(j), tab[j]);
    end
    restart();
    j = $urandom_range(31);
    fix(tab[j], 1'b1, 1'b1);
    fix(tab[j], 1'b0, 1'b0);
    np = tab[j];
    np.y = ~np.y;
    fix(np, 1'b1, 1'b0);
    np = '{16'h3000, 16'($urandom)};
    mapw(5'(j), np);
    fix(np, 1'b1, 1'b0);
    fix(tab[j], 1'b1, 1'b1);
    restart();
    fix(np, 1'b1, 1'b1);
    fix(tab[j], 1'b1, 1'b0);
    test_done();
  end
endmodule
